// file: rcc_params.svh
`ifndef RCC_PARAMS_SVH
`define RCC_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define RCC_OFS_CFG 8'h00
`define RCC_OFS_PAD 8'h04
`define RCC_OFS_VAL 8'h08

// ----------------------------------------------------------------------
// configuration register fields
// ----------------------------------------------------------------------
`define RCC_CFG_EN 15
`define RCC_CFG_WREN 13
`define RCC_CFG_SYNC 12
`define RCC_CFG_HALF 11
`define RCC_CFG_OE 10
`define RCC_CFG_PTR_HI 9
`define RCC_CFG_PTR_LO 8
`define RCC_CFG_CAL_HI 7
`define RCC_CFG_CAL_LO 0

// ----------------------------------------------------------------------
// pad register fields
// ----------------------------------------------------------------------
`define RCC_PAD_SEL_HI 2
`define RCC_PAD_SEL_LO 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RCC_CFG_RST 16'h0000
`define RCC_PAD_RST 2'h0
`define RCC_PTR_RST 2'h0

// ----------------------------------------------------------------------
// timing and bus answers
// ----------------------------------------------------------------------
`define RCC_REF_PER_SEC 32768
`define RCC_SEC_PER_MIN 6'h3b
`define RCC_RESP_OKAY 2'h0
`define RCC_RESP_SLVERR 2'h2

`endif

// file: rcc_pkg.sv
package rcc_pkg;

    // clock output pin source
    typedef enum logic [1:0] {
        RCC_SEL_ALARM,
        RCC_SEL_SECONDS,
        RCC_SEL_SOURCE,
        RCC_SEL_RESERVED
    } rcc_out_sel_type;

    // value window pointer
    typedef logic [1:0] rcc_ptr_type;

endpackage

// file: rcc_prescaler.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcc_params.svh"

module rcc_prescaler #(
    parameter int REF_PER_SEC = `RCC_REF_PER_SEC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ref_tick,
    input wire logic enable,
    input wire logic restart,
    input wire logic [7:0] cal,
    output logic half_second_flag
);
    import rcc_pkg::*;

    localparam logic signed [16:0] CNT_LAST = 17'(REF_PER_SEC - 1);
    localparam logic signed [16:0] CNT_HALF = 17'(REF_PER_SEC / 2);

    logic signed [16:0] cnt_reg, cnt_next;
    logic [5:0] sec_reg, sec_next;
    logic half_reg, half_next;
    logic min_reg, min_next;

    // ------------------------------------------------------------------
    // calibration offset: four reference pulses per step, signed
    // ------------------------------------------------------------------
    function automatic logic signed [16:0] cal_offset(input logic [7:0] c);
        cal_offset = {{7{c[7]}}, c, 2'b00};
    endfunction

    // ------------------------------------------------------------------
    // prescaler next state
    // ------------------------------------------------------------------
    always_comb begin
        cnt_next = cnt_reg;
        sec_next = sec_reg;
        min_next = 1'b0;
        if (restart) begin
            cnt_next = 17'sd0;
        end else if (enable && ref_tick) begin
            if (cnt_reg >= CNT_LAST) begin
                if (sec_reg == `RCC_SEC_PER_MIN) begin
                    sec_next = 6'h00;
                    cnt_next = cal_offset(cal);
                    min_next = 1'b1;
                end else begin
                    sec_next = sec_reg + 6'h01;
                    cnt_next = 17'sd0;
                end
            end else begin
                cnt_next = cnt_reg + 17'sd1;
            end
        end
        half_next = (cnt_next >= CNT_HALF);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 17'sd0;
            sec_reg <= 6'h00;
            half_reg <= 1'b0;
            min_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            sec_reg <= sec_next;
            half_reg <= half_next;
            min_reg <= min_next;
        end
    end

    assign half_second_flag = half_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_cal_minute_load: assert property (
        min_reg |-> cnt_reg == cal_offset($past(cal))
    ) else $error("calibration offset not loaded at minute");

    a_half_rise_point: assert property (
        $rose(half_reg) |-> $past(cnt_reg) == CNT_HALF - 17'sd1
    ) else $error("half second flag rose at wrong count");

endmodule
`default_nettype wire

// file: rcc_top.sv
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "rcc_params.svh"

module rcc_top #(
    parameter int REF_PER_SEC = `RCC_REF_PER_SEC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic soft_resetn,
    input wire logic ref_clk_in,
    input wire logic alarm_pulse_in,
    output logic clk_out_pin,
    output logic clk_out_en_n,
    output logic module_enable_out,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import rcc_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic ref_s1_reg, ref_s2_reg, ref_s3_reg;
    logic ref_tick, half_flag, restart;
    logic wr_do;
    logic aw_got_reg, aw_got_next, w_got_reg, w_got_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic en_reg, en_next, wren_reg, wren_next, oe_reg, oe_next;
    rcc_ptr_type ptr_reg, ptr_next;
    logic [7:0] cal_reg, cal_next;
    rcc_out_sel_type sel_reg, sel_next;
    logic [7:0] hi_mem [0:3];
    logic [7:0] hi_next [0:3];
    logic [7:0] lo_mem [0:3];
    logic [7:0] lo_next [0:3];
    logic clk_out_reg, clk_out_next, en_n_reg, en_n_next, out_src;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic rcc_ptr_type ptr_dec(input rcc_ptr_type p);
        ptr_dec = (p == 2'h0) ? 2'h0 : p - 2'h1;
    endfunction

    function automatic logic [15:0] cfg_image(input logic en, input logic wr,
                                            input logic hf, input logic oe,
                                            input rcc_ptr_type p,
                                            input logic [7:0] c);
        cfg_image = 16'h0000;
        cfg_image[`RCC_CFG_EN] = en;
        cfg_image[`RCC_CFG_WREN] = wr;
        cfg_image[`RCC_CFG_HALF] = hf;
        cfg_image[`RCC_CFG_OE] = oe;
        cfg_image[`RCC_CFG_PTR_HI:`RCC_CFG_PTR_LO] = p;
        cfg_image[`RCC_CFG_CAL_HI:`RCC_CFG_CAL_LO] = c;
    endfunction

    // ------------------------------------------------------------------
    // reference clock synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ref_s1_reg <= 1'b0;
            ref_s2_reg <= 1'b0;
            ref_s3_reg <= 1'b0;
        end else begin
            ref_s1_reg <= ref_clk_in;
            ref_s2_reg <= ref_s1_reg;
            ref_s3_reg <= ref_s2_reg;
        end
    end

    assign ref_tick = ref_s2_reg && !ref_s3_reg;

    rcc_prescaler #(
        .REF_PER_SEC(REF_PER_SEC)
    ) u_prescaler (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ref_tick(ref_tick),
        .enable(en_reg),
        .restart(restart),
        .cal(cal_reg),
        .half_second_flag(half_flag)
    );

    // ------------------------------------------------------------------
    // bus handshakes
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready = !w_got_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign wr_do = aw_got_reg && w_got_reg && !bvalid_reg;

    // ------------------------------------------------------------------
    // register and bus next state
    // ------------------------------------------------------------------
    always_comb begin
        aw_got_next = aw_got_reg;
        w_got_next = w_got_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        en_next = en_reg;
        wren_next = wren_reg;
        oe_next = oe_reg;
        ptr_next = ptr_reg;
        cal_next = cal_reg;
        sel_next = sel_reg;
        hi_next = hi_mem;
        lo_next = lo_mem;
        restart = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (wr_do) begin
            aw_got_next = 1'b0;
            w_got_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = `RCC_RESP_OKAY;
            case (awaddr_reg)
                `RCC_OFS_CFG: begin
                    if (wstrb_reg[1]) begin
                        if (wren_reg) begin
                            en_next = wdata_reg[`RCC_CFG_EN];
                        end
                        wren_next = wdata_reg[`RCC_CFG_WREN];
                        oe_next = wdata_reg[`RCC_CFG_OE];
                        ptr_next = wdata_reg[`RCC_CFG_PTR_HI:`RCC_CFG_PTR_LO];
                    end
                    if (wstrb_reg[0]) begin
                        cal_next = wdata_reg[`RCC_CFG_CAL_HI:`RCC_CFG_CAL_LO];
                    end
                end
                `RCC_OFS_PAD: begin
                    if (wstrb_reg[0]) begin
                        sel_next = rcc_out_sel_type'(
                            wdata_reg[`RCC_PAD_SEL_HI:`RCC_PAD_SEL_LO]);
                    end
                end
                `RCC_OFS_VAL: begin
                    if (wren_reg) begin
                        if (wstrb_reg[1] && ptr_reg != 2'h3) begin
                            hi_next[ptr_reg] = wdata_reg[15:8];
                        end
                        if (wstrb_reg[0]) begin
                            lo_next[ptr_reg] = wdata_reg[7:0];
                            restart = (ptr_reg == 2'h0);
                        end
                    end
                    if (wstrb_reg[1]) begin
                        ptr_next = ptr_dec(ptr_next);
                    end
                end
                default: bresp_next = `RCC_RESP_SLVERR;
            endcase
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next = `RCC_RESP_OKAY;
            rdata_next = 32'h0000_0000;
            case (s_axi_araddr)
                `RCC_OFS_CFG: rdata_next[15:0] = cfg_image(en_reg, wren_reg,
                    half_flag, oe_reg, ptr_reg, cal_reg);
                `RCC_OFS_PAD: rdata_next[`RCC_PAD_SEL_HI:`RCC_PAD_SEL_LO] =
                    sel_reg;
                `RCC_OFS_VAL: begin
                    rdata_next[15:8] = (ptr_reg == 2'h3) ? 8'h00
                                                         : hi_mem[ptr_reg];
                    rdata_next[7:0] = lo_mem[ptr_reg];
                    ptr_next = ptr_dec(ptr_next);
                end
                default: rresp_next = `RCC_RESP_SLVERR;
            endcase
        end
        if (!soft_resetn) begin
            sel_next = RCC_SEL_ALARM;
            for (int i = 0; i < 4; i++) begin
                hi_next[i] = 8'h00;
                lo_next[i] = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RCC_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= `RCC_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
            en_reg <= 1'(`RCC_CFG_RST >> `RCC_CFG_EN);
            wren_reg <= 1'b0;
            oe_reg <= 1'b0;
            ptr_reg <= `RCC_PTR_RST;
            cal_reg <= 8'h00;
            sel_reg <= RCC_SEL_ALARM;
            for (int i = 0; i < 4; i++) begin
                hi_mem[i] <= 8'h00;
                lo_mem[i] <= 8'h00;
            end
        end else begin
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            en_reg <= en_next;
            wren_reg <= wren_next;
            oe_reg <= oe_next;
            ptr_reg <= ptr_next;
            cal_reg <= cal_next;
            sel_reg <= sel_next;
            hi_mem <= hi_next;
            lo_mem <= lo_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign module_enable_out = en_reg;

    // ------------------------------------------------------------------
    // clock output pin
    // ------------------------------------------------------------------
    always_comb begin
        unique case (sel_reg)
            RCC_SEL_ALARM: out_src = alarm_pulse_in;
            RCC_SEL_SECONDS: out_src = half_flag;
            RCC_SEL_SOURCE: out_src = ref_s2_reg;
            RCC_SEL_RESERVED: out_src = 1'b0;
        endcase
        clk_out_next = oe_reg && out_src;
        en_n_next = !oe_reg;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            clk_out_reg <= 1'b0;
            en_n_reg <= 1'b1;
        end else begin
            clk_out_reg <= clk_out_next;
            en_n_reg <= en_n_next;
        end
    end

    assign clk_out_pin = clk_out_reg;
    assign clk_out_en_n = en_n_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    logic [63:0] val_chk;
    assign val_chk = {hi_mem[0], hi_mem[1], hi_mem[2], hi_mem[3],
                      lo_mem[0], lo_mem[1], lo_mem[2], lo_mem[3]};

    a_half_clear_write: assert property (
        wr_do && awaddr_reg == `RCC_OFS_VAL && wstrb_reg[0] && wren_reg &&
        ptr_reg == 2'h0 |=> !half_flag
    ) else $error("half flag not cleared by seconds write");

    a_pin_disabled: assert property (
        !oe_reg |=> clk_out_en_n && !clk_out_pin
    ) else $error("clock pin driven while output disabled");

    a_ptr_decrement: assert property (
        wr_do && awaddr_reg == `RCC_OFS_VAL && wstrb_reg[1] &&
        ptr_reg != 2'h0 && !(s_axi_arvalid && s_axi_arready)
        |=> ptr_reg == $past(ptr_reg) - 2'h1
    ) else $error("window pointer did not step down");

    a_ptr_floor: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `RCC_OFS_VAL &&
        ptr_reg == 2'h0 && !wr_do |=> ptr_reg == 2'h0
    ) else $error("window pointer went below zero");

    a_window_read: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == `RCC_OFS_VAL
        |=> s_axi_rdata[7:0] == lo_mem[$past(ptr_reg)]
    ) else $error("window read returned wrong pair");

    a_cfg_por_only: assert property (
        !soft_resetn && !wr_do |=> $stable({en_reg, wren_reg, oe_reg,
                                            cal_reg})
    ) else $error("config changed by soft reset");

    a_enable_locked: assert property (
        wr_do && awaddr_reg == `RCC_OFS_CFG && !wren_reg |=> $stable(en_reg)
    ) else $error("module enable written while locked");

    a_value_locked: assert property (
        wr_do && awaddr_reg == `RCC_OFS_VAL && !wren_reg && soft_resetn
        |=> $stable(val_chk)
    ) else $error("value written while locked");

    a_sel_seconds: assert property (
        oe_reg && sel_reg == RCC_SEL_SECONDS |=> clk_out_pin == $past(half_flag)
    ) else $error("seconds clock not routed to pin");

    a_write_answer: assert property (
        wr_do |=> s_axi_bvalid
    ) else $error("write answer missing");

endmodule
`default_nettype wire

// file: rcc_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcc_params.svh"
module rcc_top_bench;
    logic clk_sys = 0, resetn = 0, soft_resetn = 1, ref_clk_in = 0;
    logic alarm_pulse_in = 0, clk_out_pin, clk_out_en_n, module_enable_out;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    int num_errors = 0, tests_run = 0;
    localparam logic [7:0] CFG = `RCC_OFS_CFG, PAD = `RCC_OFS_PAD;
    localparam logic [7:0] VAL = `RCC_OFS_VAL;

    rcc_top #(.REF_PER_SEC(8)) dut (.clk_sys, .resetn, .soft_resetn,
        .ref_clk_in, .alarm_pulse_in, .clk_out_pin, .clk_out_en_n,
        .module_enable_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    always #25 clk_sys = ~clk_sys;

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        end while (!(s_axi_bvalid && s_axi_bready));
        resp = s_axi_bresp;
        s_axi_bready <= 0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        end while (!(s_axi_rvalid && s_axi_rready));
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask

    // reference pulses, four system clocks high and four low
    task automatic refp(input int n);
        repeat (n) begin
            ref_clk_in <= 1;
            repeat (4) @(posedge clk_sys);
            ref_clk_in <= 0;
            repeat (4) @(posedge clk_sys);
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd(CFG);
        chk("cfg reset", 0, rdat);
        rd(PAD);
        chk("pad reset", 0, rdat);
        chk("en_n reset", 1, clk_out_en_n);
        chk("enable reset", 0, module_enable_out);
        rd(8'h0c);
        chk("unmapped resp", `RCC_RESP_SLVERR, resp);
        chk("unmapped data", 0, rdat);
        wr(8'h0c, 32'hffff, 4'b0011);
        chk("unmapped wresp", `RCC_RESP_SLVERR, resp);
        $display("done reset");
    endtask

    task automatic t_lock();
        wr(CFG, 32'h8000, 4'b0011);
        chk("write resp", `RCC_RESP_OKAY, resp);
        chk("enable locked", 0, module_enable_out);
        wr(VAL, 32'h0055, 4'b0001);
        rd(VAL);
        chk("window locked", 0, rdat);
        chk("read resp", `RCC_RESP_OKAY, resp);
        wr(CFG, 32'h2000, 4'b0011);
        wr(CFG, 32'ha000, 4'b0011);
        chk("enable set", 1, module_enable_out);
        $display("done lock");
    endtask

    task automatic t_ptr();
        logic [15:0] v[4];
        v = '{16'h00aa, 16'h0c1f, 16'h0317, 16'h3b2d};
        wr(CFG, 32'ha300, 4'b0011);
        for (int i = 0; i < 4; i++) begin
            wr(VAL, {16'h0, v[i]}, 4'b0011);
            rd(CFG);
            chk("pointer", (i < 2) ? 2 - i : 0, rdat[9:8]);
        end
        wr(CFG, 32'ha300, 4'b0010);
        for (int i = 0; i < 5; i++) begin
            rd(VAL);
            chk("window", {16'h0, v[(i < 4) ? i : 3]}, rdat);
        end
        $display("done pointer");
    endtask

    task automatic t_half();
        wr(VAL, 32'h002d, 4'b0001);
        refp(3);
        rd(CFG);
        chk("half first", 0, rdat[11]);
        refp(1);
        rd(CFG);
        chk("half second", 1, rdat[11]);
        wr(CFG, 32'ha000, 4'b0010);
        rd(CFG);
        chk("half read only", 1, rdat[11]);
        wr(VAL, 32'h002d, 4'b0001);
        rd(CFG);
        chk("half cleared", 0, rdat[11]);
        $display("done half");
    endtask

    task automatic t_cal();
        logic [7:0] c[2];
        int p[2];
        c = '{8'h01, 8'hff};
        p = '{480, 484};
        for (int i = 0; i < 2; i++) begin
            wr(CFG, {24'h0, c[i]}, 4'b0001);
            wr(VAL, 32'h002d, 4'b0001);
            refp(p[i]);
            rd(CFG);
            chk("cal phase", 1 - i, rdat[11]);
            chk("cal kept", c[i], rdat[7:0]);
        end
        wr(CFG, 32'h0, 4'b0001);
        $display("done calibration");
    endtask

    task automatic t_pin();
        logic e;
        wr(CFG, 32'ha400, 4'b0010);
        wr(VAL, 32'h002d, 4'b0001);
        refp(4);
        for (int s = 0; s < 4; s++) begin
            wr(PAD, s << 1, 4'b0011);
            rd(PAD);
            chk("pad sel", s << 1, rdat);
            for (int v = 0; v < 2; v++) begin
                alarm_pulse_in <= v[0];
                ref_clk_in <= v[0];
                repeat (6) @(posedge clk_sys);
                e = (s == 1) ? 1'b1 : (s == 3) ? 1'b0 : v[0];
                chk("pin", e, clk_out_pin);
                chk("pin en_n", 0, clk_out_en_n);
            end
        end
        wr(PAD, 32'h4, 4'b0011);
        wr(CFG, 32'ha000, 4'b0010);
        repeat (3) @(posedge clk_sys);
        chk("pin off", 0, clk_out_pin);
        chk("en_n off", 1, clk_out_en_n);
        $display("done pin");
    endtask

    task automatic t_soft();
        wr(CFG, 32'h0055, 4'b0001);
        soft_resetn <= 0;
        repeat (3) @(posedge clk_sys);
        soft_resetn <= 1;
        rd(CFG);
        chk("cfg kept", 32'ha055, rdat & 32'hf7ff);
        rd(PAD);
        chk("pad cleared", 0, rdat);
        rd(VAL);
        chk("value cleared", 0, rdat);
        resetn <= 0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1;
        rd(CFG);
        chk("cfg por", 0, rdat);
        chk("enable por", 0, module_enable_out);
        refp(4);
        rd(CFG);
        chk("disabled count", 0, rdat[11]);
        $display("done soft reset");
    endtask

    initial begin
        repeat (40000) @(posedge clk_sys);
        num_errors++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1;
        t_reset();
        t_lock();
        t_ptr();
        t_half();
        t_cal();
        t_pin();
        t_soft();
        end_sim();
    end
endmodule
`default_nettype wire
